// ---- rtl/scp_defines.svh ----
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// interface mode that turns the shared pins into the config port
`define SCP_MODE_SERIAL 2'h3

// timing
`define SCP_CLK_NS      40
`define SCP_CONV_NS     3000
`define SCP_CONV_CYC    ((`SCP_CONV_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_HALF_CYC    4
`define SCP_CNV_LOW_CYC 2

// serial configuration word
`define SCP_CFG_W       8
`define SCP_CFG_RST     8'h00
`define SCP_CFG_POL     0
`define SCP_CFG_SPAN    1

// shared pins and result width
`define SCP_RES_W       18
`define SCP_BIT_LO      15

// synchroniser vector: mode[9:8] src[7] inv[6] span[5] pol[4]
// cnvst_n[3] pin17[2] pin16[1] pin15[0]
`define SCP_SYNC_W      10
`define SCP_SYNC_RST    10'h08c

`endif

// ---- rtl/scp_pkg.sv ----
package scp_pkg;

  // analog input range chosen from polarity and span
  typedef enum logic [1:0] {
    SCP_RNG_U5  = 2'h0,
    SCP_RNG_U10 = 2'h1,
    SCP_RNG_B5  = 2'h2,
    SCP_RNG_B10 = 2'h3
  } scp_range_t;

  typedef enum logic [4:0] {
    SCP_H_IDLE = 5'h01,
    SCP_H_LEAD = 5'h02,
    SCP_H_ACT  = 5'h04,
    SCP_H_TAIL = 5'h08,
    SCP_H_GAP  = 5'h10
  } scp_hst_t;

  function automatic scp_range_t scp_range(input logic pol,
                                            input logic span);
    scp_range = scp_range_t'({pol, span});
  endfunction

endpackage

// ---- rtl/scp_if.sv ----
`timescale 1ns/1ps
interface scp_if;
  // static strap pins and the conversion start, driven by the host
  logic [1:0] mode;
  logic       cfg_src;
  logic       clk_inv;
  logic       span_sel;
  logic       pol_sel;
  logic       cnvst_n;
  // conversion status, driven by the device
  logic       busy;
  // shared pins: 0 = bit15/serial in, 1 = bit16/clock, 2 = bit17/select
  logic [2:0] dev_o;
  logic [2:0] dev_oe;
  logic [2:0] host_o;
  logic [2:0] host_oe;
  logic [2:0] pin;

  assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o);

  modport dev (
    input  mode, cfg_src, clk_inv, span_sel, pol_sel, cnvst_n, pin,
    output busy, dev_o, dev_oe
  );
  modport host (
    output mode, cfg_src, clk_inv, span_sel, pol_sel, cnvst_n,
    output host_o, host_oe,
    input  busy, pin
  );
endinterface

// ---- rtl/scp_dev.sv ----
// Overview of operation
// - modes 0-2: shared pins drive result bits 15-17
// - mode 3: shared pins become config port inputs
// - config bits shift in msb first
// - data sampled on selectable active clock edge
// - source select low in mode 3: serial register configures
// - writes accepted only while port is selected
// - busy high from start until result latched
// - host may use busy fall as ready
// - range chosen from span and polarity levels
// - reset aborts conversion, clears config register
`timescale 1ns/1ps
`include "scp_defines.svh"
module scp_dev #(
  parameter int CFG_W    = `SCP_CFG_W,
  parameter int CONV_CYC = `SCP_CONV_CYC,
  parameter int RES_W    = `SCP_RES_W
) (
  // clock and reset
  input  wire logic                CLK_IN,
  input  wire logic                RST_N_IN,
  // link to the host
  scp_if.dev                       LINK,
  // converter core result
  input  wire logic [RES_W-1:0]    RESULT_IN,
  // status and configuration
  output logic      [RES_W-1:0]    RESULT_OUT,
  output logic      [CFG_W-1:0]    CFG_WORD_OUT,
  output scp_pkg::scp_range_t      RANGE_OUT,
  output logic                     SERIAL_MODE_OUT,
  output logic                     BUSY_OUT
);

  localparam int CW = $clog2(CFG_W + 2);
  localparam int TW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(CFG_W);
  localparam logic [CW-1:0] CNT_OVER = CW'(CFG_W + 1);
  localparam logic [TW-1:0] CONV_END = TW'(CONV_CYC - 1);

  // three-stage synchroniser on every pin from the host
  logic [`SCP_SYNC_W-1:0] raw;
  logic [`SCP_SYNC_W-1:0] s1_q;
  logic [`SCP_SYNC_W-1:0] s2_q;
  logic [`SCP_SYNC_W-1:0] s3_q;
  logic [`SCP_SYNC_W-1:0] stb_q;
  logic [`SCP_SYNC_W-1:0] stb_d;
  logic [`SCP_SYNC_W-1:0] prv_q;

  assign raw = {LINK.mode, LINK.cfg_src, LINK.clk_inv, LINK.span_sel,
                LINK.pol_sel, LINK.cnvst_n, LINK.pin};
  // a bit only moves once stages two and three agree
  assign stb_d = (s2_q & ~(s2_q ^ s3_q)) | (stb_q & (s2_q ^ s3_q));

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s1_q  <= `SCP_SYNC_RST;
      s2_q  <= `SCP_SYNC_RST;
      s3_q  <= `SCP_SYNC_RST;
      stb_q <= `SCP_SYNC_RST;
      prv_q <= `SCP_SYNC_RST;
    end else begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      stb_q <= stb_d;
      prv_q <= stb_q;
    end
  end

  // decoded pin levels
  wire [1:0] mode_w    = stb_q[9:8];
  wire       src_w     = stb_q[7];
  wire       inv_w     = stb_q[6];
  wire       span_w    = stb_q[5];
  wire       pol_w     = stb_q[4];
  wire       sin_w     = stb_q[0];
  wire       sclk_w    = stb_q[1];
  wire       cs_n_w    = stb_q[2];
  wire       ser_mode  = (mode_w == `SCP_MODE_SERIAL);
  wire       sw_cfg    = ser_mode & ~src_w;
  wire       cnv_fall  = prv_q[3] & ~stb_q[3];
  wire       cs_rise   = ~prv_q[2] & cs_n_w;
  // active edge: rising when invert is low, falling when high
  wire       sclk_act  = (prv_q[1] != sclk_w) & (sclk_w == ~inv_w);
  wire       shift_en  = sw_cfg & ~cs_n_w & sclk_act;

  // serial configuration shifter
  logic [CFG_W-1:0] sh_q;
  logic [CFG_W-1:0] cfg_q;
  logic [CW-1:0]    cnt_q;

  wire [CW-1:0] cnt_inc = (cnt_q == CNT_OVER) ? cnt_q : cnt_q + CW'(1);
  wire          commit  = cs_rise & sw_cfg & (cnt_q == CNT_FULL);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sh_q <= `SCP_CFG_RST;
    end else if (shift_en) begin
      sh_q <= {sh_q[CFG_W-2:0], sin_w};
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_q <= '0;
    end else if (cs_n_w || !sw_cfg) begin
      cnt_q <= '0;
    end else if (shift_en) begin
      cnt_q <= cnt_inc;
    end
  end

  // a frame with too few or too many bits is dropped whole
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg_q <= `SCP_CFG_RST;
    end else if (commit) begin
      cfg_q <= sh_q;
    end
  end

  // effective configuration
  wire               eff_pol  = sw_cfg ? cfg_q[`SCP_CFG_POL]  : pol_w;
  wire               eff_span = sw_cfg ? cfg_q[`SCP_CFG_SPAN] : span_w;
  scp_pkg::scp_range_t range_d;
  scp_pkg::scp_range_t range_q;

  assign range_d = scp_pkg::scp_range(eff_pol, eff_span);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      range_q <= scp_pkg::SCP_RNG_U5;
    end else begin
      range_q <= range_d;
    end
  end

  // conversion timer
  logic             busy_q;
  logic [TW-1:0]    tmr_q;
  logic [RES_W-1:0] res_q;

  wire conv_done = busy_q & (tmr_q == CONV_END);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
    end else if (cnv_fall && !busy_q) begin
      busy_q <= 1'b1;
      tmr_q  <= '0;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tmr_q  <= tmr_q + TW'(1);
    end
  end

  // result latched in the same edge that drops busy
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      res_q <= '0;
    end else if (conv_done) begin
      res_q <= RESULT_IN;
    end
  end

  // shared pins: outputs in parallel modes, inputs in serial mode
  // new result reaches the pins on the edge that drops busy
  wire [RES_W-1:0] res_d = conv_done ? RESULT_IN : res_q;
  logic [2:0] pin_o_q;
  logic       pin_oe_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_o_q  <= 3'h0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q  <= res_d[`SCP_BIT_LO +: 3];
      pin_oe_q <= ~ser_mode;
    end
  end

  // no path ever puts configuration contents onto the pins
  assign LINK.dev_o    = pin_o_q;
  assign LINK.dev_oe   = {3{pin_oe_q}};
  assign LINK.busy     = busy_q;
  assign RESULT_OUT    = res_q;
  assign CFG_WORD_OUT  = cfg_q;
  assign RANGE_OUT     = range_q;
  assign BUSY_OUT      = busy_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SERIAL_MODE_OUT <= 1'b0;
    end else begin
      SERIAL_MODE_OUT <= ser_mode;
    end
  end

endmodule

// ---- rtl/scp_host.sv ----
// The host takes plain request inputs; it has no address-and-strobe port and no register offsets.
`timescale 1ns/1ps
`include "scp_defines.svh"
module scp_host #(
  parameter int CFG_W    = `SCP_CFG_W,
  parameter int HALF_CYC = `SCP_HALF_CYC
) (
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  // link to the device
  scp_if.host                    LINK,
  // strap settings
  input  wire logic [1:0]        MODE_IN,
  input  wire logic              CFG_SRC_IN,
  input  wire logic              CLK_INV_IN,
  input  wire logic              SPAN_IN,
  input  wire logic              POL_IN,
  // requests
  input  wire logic              CONV_REQ_IN,
  input  wire logic              WR_REQ_IN,
  input  wire logic [CFG_W-1:0]  WR_DATA_IN,
  output logic                   WR_READY_OUT,
  // results
  output logic      [2:0]        RESULT_HI_OUT,
  output logic                   DATA_READY_OUT,
  output logic                   BUSY_OUT
);

  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int BW = $clog2(CFG_W + 1);
  localparam int LW = $clog2(`SCP_CNV_LOW_CYC + 1);
  localparam logic [HW-1:0] HALF_END = HW'(HALF_CYC - 1);
  localparam logic [LW-1:0] LOW_END  = LW'(`SCP_CNV_LOW_CYC - 1);

  // strap registers
  logic [1:0] mode_q;
  logic [3:0] strap_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q  <= 2'h0;
      strap_q <= 4'h8;
    end else begin
      mode_q  <= MODE_IN;
      strap_q <= {CFG_SRC_IN, CLK_INV_IN, SPAN_IN, POL_IN};
    end
  end

  wire ser_mode = (mode_q == `SCP_MODE_SERIAL);
  wire sw_cfg   = ser_mode & ~strap_q[3];

  // half-period divider for the generated config clock
  scp_pkg::scp_hst_t st_q;
  logic [HW-1:0]     div_q;
  logic [BW-1:0]     bit_q;
  logic [CFG_W-1:0]  sh_q;
  logic              act_q;
  logic              cs_n_q;

  wire tick  = (st_q != scp_pkg::SCP_H_IDLE) & (div_q == HALF_END);
  wire start = WR_REQ_IN & (st_q == scp_pkg::SCP_H_IDLE) & sw_cfg;

  assign WR_READY_OUT = (st_q == scp_pkg::SCP_H_IDLE) & sw_cfg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_q <= '0;
    end else if (start || tick) begin
      div_q <= '0;
    end else if (st_q != scp_pkg::SCP_H_IDLE) begin
      div_q <= div_q + HW'(1);
    end
  end

  // data moves on the inactive edge, device samples the active one
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q   <= scp_pkg::SCP_H_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      act_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      case (st_q)
        scp_pkg::SCP_H_IDLE: begin
          if (start) begin
            sh_q   <= WR_DATA_IN;
            bit_q  <= '0;
            cs_n_q <= 1'b0;
            st_q   <= scp_pkg::SCP_H_LEAD;
          end
        end
        scp_pkg::SCP_H_LEAD: begin
          if (tick) begin
            act_q <= 1'b1;
            st_q  <= scp_pkg::SCP_H_ACT;
          end
        end
        scp_pkg::SCP_H_ACT: begin
          if (tick) begin
            act_q <= 1'b0;
            bit_q <= bit_q + BW'(1);
            sh_q  <= {sh_q[CFG_W-2:0], 1'b0};
            st_q  <= (bit_q == BW'(CFG_W - 1)) ? scp_pkg::SCP_H_TAIL
                                                : scp_pkg::SCP_H_LEAD;
          end
        end
        scp_pkg::SCP_H_TAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            st_q   <= scp_pkg::SCP_H_GAP;
          end
        end
        scp_pkg::SCP_H_GAP: begin
          if (tick) begin
            st_q <= scp_pkg::SCP_H_IDLE;
          end
        end
        default: begin
          st_q   <= scp_pkg::SCP_H_IDLE;
          cs_n_q <= 1'b1;
          act_q  <= 1'b0;
        end
      endcase
    end
  end

  // conversion start pulse, low for a few cycles
  logic          cnv_n_q;
  logic [LW-1:0] cnv_cnt_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnv_n_q   <= 1'b1;
      cnv_cnt_q <= '0;
    end else if (CONV_REQ_IN && cnv_n_q) begin
      cnv_n_q   <= 1'b0;
      cnv_cnt_q <= '0;
    end else if (!cnv_n_q) begin
      cnv_cnt_q <= cnv_cnt_q + LW'(1);
      cnv_n_q   <= (cnv_cnt_q == LOW_END);
    end
  end

  // busy and result bits from the device, three-stage synchronised
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] stb_q;
  logic [3:0] stb_d;

  assign stb_d = (s2_q & ~(s2_q ^ s3_q)) | (stb_q & (s2_q ^ s3_q));
  wire busy_fall = stb_q[3] & ~stb_d[3];

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      stb_q <= 4'h0;
    end else begin
      s1_q  <= {LINK.busy, LINK.pin};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      stb_q <= stb_d;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RESULT_HI_OUT  <= 3'h0;
      DATA_READY_OUT <= 1'b0;
    end else begin
      DATA_READY_OUT <= busy_fall & ~ser_mode;
      if (busy_fall && !ser_mode) begin
        RESULT_HI_OUT <= stb_d[2:0];
      end
    end
  end

  assign BUSY_OUT     = stb_q[3];
  assign LINK.mode     = mode_q;
  assign LINK.cfg_src  = strap_q[3];
  assign LINK.clk_inv  = strap_q[2];
  assign LINK.span_sel = strap_q[1];
  assign LINK.pol_sel  = strap_q[0];
  assign LINK.cnvst_n  = cnv_n_q;
  // pin0 data msb first, pin1 clock, pin2 select active low
  assign LINK.host_o   = {cs_n_q, act_q ^ strap_q[2],
                          sh_q[CFG_W-1]};
  assign LINK.host_oe  = {3{ser_mode}};

endmodule

// ---- sim/scp_chk.sv ----
`timescale 1ns/1ps
module scp_chk #(
  parameter int CONV_CYC = 75
) (
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  // link signals
  input  wire logic [1:0] mode,
  input  wire logic       clk_inv,
  input  wire logic       cnvst_n,
  input  wire logic       busy,
  input  wire logic [2:0] pin,
  input  wire logic [2:0] dev_oe,
  input  wire logic [2:0] host_oe
);
  logic [7:0] busy_cnt_q;
  logic [3:0] since_q;
  logic       clk_pin_q;
  logic [3:0] edge_cnt_q;

  // host alone owns the shared pins
  wire        serial_link = (mode == 2'h3) & host_oe[2] & (dev_oe == 3'h0);
  wire        in_frame    = serial_link & ~pin[2];
  wire        act_edge    = clk_inv ? (clk_pin_q & ~pin[1])
                                    : (~clk_pin_q & pin[1]);
  wire [7:0]  busy_cnt_d  = busy ? busy_cnt_q + 8'h01 : 8'h00;
  wire [3:0]  since_d     = !cnvst_n ? 4'h0 :
                            (since_q == 4'hf) ? since_q : since_q + 4'h1;
  wire [3:0]  edge_cnt_d  = in_frame ? edge_cnt_q + {3'h0, act_edge} : 4'h0;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      busy_cnt_q <= 8'h00;
      since_q    <= 4'hf;
      clk_pin_q  <= 1'b0;
      edge_cnt_q <= 4'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      since_q    <= since_d;
      clk_pin_q  <= pin[1];
      edge_cnt_q <= edge_cnt_d;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence act_edge_s;
    in_frame && (clk_inv ? $fell(pin[1]) : $rose(pin[1]));
  endsequence

  sequence frame_end_s;
    serial_link && $past(host_oe[2]) && ($past(dev_oe) == 3'h0)
      && $rose(pin[2]);
  endsequence

  par_drive_a: assert property (
    (mode != 2'h3) [*8] |-> dev_oe == 3'h7)
    else $error("result pins not driven in parallel mode");
  serial_hiz_a: assert property (
    (mode == 2'h3) [*8] |-> dev_oe == 3'h0)
    else $error("device drives config pins in serial mode");
  data_stable_a: assert property (
    act_edge_s |-> $stable(pin[0]) ##1 $stable(pin[0]) [*3])
    else $error("config data moved around active edge");
  clk_idle_a: assert property (
    serial_link && pin[2] && (clk_inv == $past(clk_inv, 2))
      |-> pin[1] == clk_inv)
    else $error("config clock not idle between frames");
  frame_bits_a: assert property (
    frame_end_s |-> edge_cnt_q == 4'h8)
    else $error("config frame without eight clock edges");
  busy_start_a: assert property (
    $fell(cnvst_n) && !busy |-> ##[2:8] busy)
    else $error("busy did not rise after conversion start");
  busy_len_a: assert property (
    $fell(busy) |-> busy_cnt_q == 8'(CONV_CYC))
    else $error("busy length differs from conversion time");
  busy_cause_a: assert property (
    $rose(busy) |-> since_q <= 4'h8)
    else $error("busy rose without a conversion start");
endmodule

// ---- sim/serial_config_port_pins_test.sv ----
`timescale 1ns/1ps
module serial_config_port_pins_test;
  localparam int CONV  = 20;
  localparam int LIMIT = 30000;
  localparam scp_pkg::scp_range_t RNG_TAB [4] = '{scp_pkg::SCP_RNG_U5,
    scp_pkg::SCP_RNG_U10, scp_pkg::SCP_RNG_B5, scp_pkg::SCP_RNG_B10};
  logic                clk;
  logic                rst_n;
  logic [1:0]          s_mode;
  logic                s_src, s_inv, s_span, s_pol;
  logic                conv_req, wr_req, wr_ready, data_ready;
  logic                ser_mode, dev_busy, host_busy;
  logic [7:0]          wr_data, cfg_word, cfg_b;
  logic [17:0]         res_in, res_out;
  logic [2:0]          res_hi;
  scp_pkg::scp_range_t rng;
  int                  err_count = 0;
  int                  tests_run = 0;
  int                  cyc = 0;

  scp_if u_scp_if ();
  scp_if u_bad_if ();
  scp_dev #(.CONV_CYC(CONV)) u_scp_dev (.CLK_IN(clk), .RST_N_IN(rst_n),
    .LINK(u_scp_if.dev), .RESULT_IN(res_in), .RESULT_OUT(res_out),
    .CFG_WORD_OUT(cfg_word), .RANGE_OUT(rng), .SERIAL_MODE_OUT(ser_mode),
    .BUSY_OUT(dev_busy));
  scp_host u_scp_host (.CLK_IN(clk), .RST_N_IN(rst_n),
    .LINK(u_scp_if.host), .MODE_IN(s_mode), .CFG_SRC_IN(s_src),
    .CLK_INV_IN(s_inv), .SPAN_IN(s_span), .POL_IN(s_pol),
    .CONV_REQ_IN(conv_req), .WR_REQ_IN(wr_req), .WR_DATA_IN(wr_data),
    .WR_READY_OUT(wr_ready), .RESULT_HI_OUT(res_hi),
    .DATA_READY_OUT(data_ready), .BUSY_OUT(host_busy));
  // second device faced by a rule-breaking driver
  scp_dev #(.CONV_CYC(CONV)) u_scp_dev_b (.CLK_IN(clk), .RST_N_IN(rst_n),
    .LINK(u_bad_if.dev), .RESULT_IN(18'h00000), .RESULT_OUT(),
    .CFG_WORD_OUT(cfg_b), .RANGE_OUT(), .SERIAL_MODE_OUT(), .BUSY_OUT());
  scp_chk #(.CONV_CYC(CONV)) u_scp_chk (.CLK_IN(clk), .RST_N_IN(rst_n),
    .mode(u_scp_if.mode), .clk_inv(u_scp_if.clk_inv),
    .cnvst_n(u_scp_if.cnvst_n), .busy(u_scp_if.busy), .pin(u_scp_if.pin),
    .dev_oe(u_scp_if.dev_oe), .host_oe(u_scp_if.host_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic straps(input logic [1:0] m, input logic [3:0] f);
    @(posedge clk);
    s_mode <= m;
    {s_src, s_inv, s_span, s_pol} <= f;
    tick(10);
  endtask

  task automatic pulse_conv();
    conv_req <= 1'b1;
    @(posedge clk);
    conv_req <= 1'b0;
  endtask

  task automatic cfg_write(input logic [7:0] d);
    for (int k = 0; k < 200 && wr_ready !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    wr_req  <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_req  <= 1'b0;
    tick(100);
  endtask

  task automatic t_parallel();
    logic [17:0] v;
    for (int m = 0; m < 3; m++) begin
      v = 18'h2a5a5 ^ (18'h08000 << m);
      straps(m[1:0], 4'h8);
      res_in <= v;
      pulse_conv();
      tick(8);
      // second start while busy must be ignored
      pulse_conv();
      for (int k = 0; k < 200 && data_ready !== 1'b1; k++) @(negedge clk);
      chk(dev_busy, 1'b0);
      chk(res_out, v);
      chk(res_hi, v[17:15]);
      chk(u_scp_if.pin, v[17:15]);
      chk(host_busy, 1'b0);
      chk(ser_mode, 1'b0);
    end
  endtask

  task automatic t_serial();
    logic [7:0] w [4] = '{8'h3c, 8'h82, 8'h41, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      // straps opposite to the word so the source is visible
      straps(2'h3, {1'b0, i[0], ~w[i][1], ~w[i][0]});
      cfg_write(w[i]);
      @(negedge clk);
      chk(cfg_word, w[i]);
      chk(rng, RNG_TAB[{w[i][0], w[i][1]}]);
      chk(ser_mode, 1'b1);
    end
  endtask

  task automatic t_hw_src();
    for (int j = 0; j < 4; j++) begin
      straps(2'h3, {2'b10, j[0], j[1]});
      @(negedge clk);
      chk(wr_ready, 1'b0);
      cfg_write(8'h00);
      @(negedge clk);
      chk(cfg_word, 8'hc3);
      chk(rng, RNG_TAB[{j[1], j[0]}]);
    end
  endtask

  task automatic t_reset_abort();
    straps(2'h0, 4'h8);
    pulse_conv();
    tick(8);
    chk(dev_busy, 1'b1);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(dev_busy, 1'b0);
    chk(cfg_word, 8'h00);
    chk(res_out, 18'h00000);
    tick(10);
  endtask

  task automatic bad_frame(input logic cs, input int n, input logic [7:0] d);
    @(posedge clk);
    u_bad_if.host_o[2] <= cs;
    for (int i = 0; i < n; i++) begin
      u_bad_if.host_o[0] <= d[7-i];
      tick(4);
      u_bad_if.host_o[1] <= 1'b1;
      tick(4);
      u_bad_if.host_o[1] <= 1'b0;
    end
    tick(4);
    u_bad_if.host_o[2] <= 1'b1;
    tick(12);
  endtask

  task automatic t_bad_port();
    bad_frame(1'b1, 8, 8'hff);
    chk(cfg_b, 8'h00);
    bad_frame(1'b0, 7, 8'hff);
    chk(cfg_b, 8'h00);
    bad_frame(1'b0, 8, 8'h5a);
    chk(cfg_b, 8'h5a);
  endtask

  initial begin
    rst_n = 1'b0;
    s_mode = 2'h0;
    {s_src, s_inv, s_span, s_pol} = 4'h8;
    {conv_req, wr_req} = 2'h0;
    wr_data = 8'h00;
    res_in = 18'h00000;
    u_bad_if.mode = 2'h3;
    {u_bad_if.cfg_src, u_bad_if.clk_inv} = 2'h0;
    {u_bad_if.span_sel, u_bad_if.pol_sel} = 2'h0;
    u_bad_if.cnvst_n = 1'b1;
    u_bad_if.host_oe = 3'h7;
    u_bad_if.host_o = 3'h4;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(10);
    t_parallel();
    t_serial();
    t_hw_src();
    t_reset_abort();
    t_bad_port();
    complete_run();
  end
endmodule
